/* File: core/microcore_mode_set_decoder.sv */
// mode-set instruction decoder of one microcore, with wishbone view
// assumes: instruction word and datapath inputs come from mclk logic
// Notes on behaviour
// - selector 000..111 picks control bits 8..15
// - control-bit opcode layout: level bit4, select 2:0
// - eight codes choose visible shared register
// - shared selector resets to own register
// - shared-select opcode pattern, code in bits 2:0
// - converter modes: direct, auto current, vds
// - mode acts on shortcut-2 low side 7/8
// - converter mode resets direct; opcode pattern
// - value mode returns low byte values
// - offset mode high slice; full both
// - null mode: nothing, combined gives boost
// - dac mode resets to value; opcode pattern
// - word mode loads all sixteen bits
// - byte modes load byte, upper cleared
// - swap mode exchanges bytes
// - read mode governs later loads; resets word
// - read-mode opcode pattern, mode bits 1:0
// - end-of-actuation bootstrap codes on allowed sides
// - mask forces source monitoring to zero on allowed sides
// - end-of-actuation pattern; unmasked, neutral defaults
// - level 0 low, 1 high
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`include "mcore_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module microcore_mode_set_decoder #(
  parameter int HS_COUNT = 7
) (
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                instrValid,
  input  wire logic [15:0]         instrWord,
  output logic                     modeHit,
  output logic      [7:0]          ctrlHigh,
  output logic      [2:0]          sharedSel,
  input  wire logic [3:0]          shortcut2Sel,
  output logic      [1:0]          converterMode,
  output logic                     convOnLs7,
  output logic                     convOnLs8,
  output logic      [1:0]          dacSliceMode,
  output logic      [1:0]          ramReadMode,
  input  wire logic                dacIsCombined,
  input  wire logic [7:0]          dacValue,
  input  wire logic [5:0]          dacOffset,
  input  wire logic [7:0]          thrHigh,
  input  wire logic [3:0]          thrNeg,
  input  wire logic [7:0]          boostValue,
  output logic      [15:0]         dacReadData,
  input  wire logic                ramLoadReq,
  input  wire logic [15:0]         ramWord,
  output logic      [15:0]         ramLoadData,
  output logic                     ramLoadValid,
  input  wire logic [HS_COUNT-1:0] hsAllowed,
  input  wire logic [HS_COUNT-1:0] srcThreshRaw,
  output logic      [HS_COUNT-1:0] srcThreshSeen,
  output logic      [HS_COUNT-1:0] bootEnable,
  output logic      [HS_COUNT-1:0] bootForceOff,
  output logic                     eoaMask
);

  // ********************************
  // opcode recognition
  // ********************************
  logic isCrb;
  logic isCrt;
  logic isDcc;
  logic isDm;
  logic isDrm;
  logic isEoa;

  assign isCrb = instrValid && ((instrWord & `CRB_MASK) == `CRB_VAL);
  assign isCrt = instrValid && ((instrWord & `CRT_MASK) == `CRT_VAL);
  assign isDcc = instrValid && ((instrWord & `DCC_MASK) == `DCC_VAL);
  assign isDm  = instrValid && ((instrWord & `DM_MASK) == `DM_VAL);
  assign isDrm = instrValid && ((instrWord & `DRM_MASK) == `DRM_VAL);
  assign isEoa = instrValid && ((instrWord & `EOA_MASK) == `EOA_VAL);

  logic anyHit;
  assign anyHit = isCrb || isCrt || isDcc || isDm || isDrm || isEoa;

  // ********************************
  // wishbone slave
  // ********************************
  // one wait state: ack rises the cycle after the request appears
  logic        ack_reg;
  logic        wbReq;
  logic        wbWrite;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic [31:0] modeWord;
  logic [15:0] count_reg;

  assign wbReq    = wb_cyc_i && wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wbWrite  = wbReq && wb_we_i && ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wbReq && !ack_reg;
    end
  end

  always_comb begin
    rdat_next = 32'h0000_0000;
    if (wb_adr_i == `MODE_ADDR) begin
      rdat_next = modeWord;
    end else if (wb_adr_i == `CTRL_ADDR) begin
      rdat_next = {24'h00_0000, ctrlHigh};
    end else if (wb_adr_i == `COUNT_ADDR) begin
      rdat_next = {16'h0000, count_reg};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wbReq && !ack_reg) begin
      rdat_reg <= rdat_next;
    end
  end

  logic ctrlWrite;
  assign ctrlWrite = wbWrite && (wb_adr_i == `CTRL_ADDR) && wb_sel_i[0];

  // ********************************
  // control register upper bits
  // ********************************
  // a set-control-bit in the same cycle as a bus write wins on its bit
  logic [2:0] control_bit_selector;
  logic       crbLevel;
  assign control_bit_selector = instrWord[2:0];
  assign crbLevel = instrWord[`CRB_LVL_BIT];

  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_ctrl
      always_ff @(posedge mclk) begin
        if (srst) begin
          ctrlHigh[gb] <= 1'b0;
        end else if (isCrb && (control_bit_selector == 3'(gb))) begin
          ctrlHigh[gb] <= crbLevel;
        end else if (ctrlWrite) begin
          ctrlHigh[gb] <= wb_dat_i[gb];
        end
      end
    end
  endgenerate

  // ********************************
  // shared register select
  // ********************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      sharedSel <= `SHARE_RST;
    end else if (isCrt) begin
      sharedSel <= instrWord[2:0];
    end
  end

  // ********************************
  // converter control mode
  // ********************************
  mcore_pkg::conv_mode_t convMode_reg;
  mcore_pkg::conv_mode_t convCode;
  logic [1:0]            convTarget_reg;
  assign convCode = mcore_pkg::conv_mode_t'(instrWord[1:0]);

  always_ff @(posedge mclk) begin
    if (srst) begin
      convMode_reg <= mcore_pkg::conv_mode_t'(`CONV_RST);
    end else if (isDcc && (convCode != mcore_pkg::CONV_RSVD)) begin
      convMode_reg <= convCode;
    end
  end

  // the low side is caught when the mode is set; a later shortcut
  // change leaves the converter where it was
  always_ff @(posedge mclk) begin
    if (srst) begin
      convTarget_reg <= `TGT_RST;
    end else if (isDcc && (convCode != mcore_pkg::CONV_RSVD)) begin
      if (shortcut2Sel == `LS7_CODE) begin
        convTarget_reg <= 2'h1;
      end else if (shortcut2Sel == `LS8_CODE) begin
        convTarget_reg <= 2'h2;
      end
    end
  end

  assign converterMode = convMode_reg;
  assign convOnLs7     = convTarget_reg[0];
  assign convOnLs8     = convTarget_reg[1];

  // ********************************
  // read-path mode latches
  // ********************************
  mode_if modes ();

  always_ff @(posedge mclk) begin
    if (srst) begin
      modes.dacMode <= mcore_pkg::dac_mode_t'(`DAC_RST);
    end else if (isDm) begin
      modes.dacMode <= mcore_pkg::dac_mode_t'(instrWord[1:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      modes.ramMode <= mcore_pkg::ram_mode_t'(`RAM_RST);
    end else if (isDrm) begin
      modes.ramMode <= mcore_pkg::ram_mode_t'(instrWord[1:0]);
    end
  end

  assign dacSliceMode = modes.dacMode;
  assign ramReadMode  = modes.ramMode;

  dac_read_router u_dac (
    .mclk       (mclk),
    .srst       (srst),
    .modes      (modes),
    .isCombined (dacIsCombined),
    .dacValue   (dacValue),
    .dacOffset  (dacOffset),
    .thrHigh    (thrHigh),
    .thrNeg     (thrNeg),
    .boostValue (boostValue),
    .readData   (dacReadData)
  );

  ram_read_shaper u_ram (
    .mclk      (mclk),
    .srst      (srst),
    .modes     (modes),
    .loadReq   (ramLoadReq),
    .ramWord   (ramWord),
    .loadData  (ramLoadData),
    .loadValid (ramLoadValid)
  );

  // ********************************
  // end of actuation
  // ********************************
  mcore_pkg::boot_code_t boot_reg;
  mcore_pkg::boot_code_t bootCode;
  logic                  mask_reg;
  assign bootCode = mcore_pkg::boot_code_t'(instrWord[1:0]);

  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_reg <= `EOA_MASK_RST;
    end else if (isEoa) begin
      mask_reg <= instrWord[`EOA_MASK_BIT];
    end
  end

  // keep means the last code stays in force
  always_ff @(posedge mclk) begin
    if (srst) begin
      boot_reg <= mcore_pkg::boot_code_t'(`EOA_BOOT_RST);
    end else if (isEoa && (bootCode != mcore_pkg::BOOT_KEEP)) begin
      boot_reg <= bootCode;
    end
  end

  assign eoaMask = mask_reg;

  // only high sides this core may drive are touched
  genvar gh;
  generate
    for (gh = 0; gh < HS_COUNT; gh++) begin : g_hs
      always_ff @(posedge mclk) begin
        if (srst) begin
          srcThreshSeen[gh] <= 1'b0;
          bootEnable[gh]    <= 1'b0;
          bootForceOff[gh]  <= 1'b0;
        end else begin
          srcThreshSeen[gh] <= srcThreshRaw[gh] && !(mask_reg && hsAllowed[gh]);
          bootEnable[gh]    <= hsAllowed[gh] && (boot_reg == mcore_pkg::BOOT_ON);
          bootForceOff[gh]  <= hsAllowed[gh] && (boot_reg == mcore_pkg::BOOT_OFF);
        end
      end
    end
  endgenerate

  // ********************************
  // status
  // ********************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      modeHit <= 1'b0;
    end else begin
      modeHit <= anyHit;
    end
  end

  // wraps silently; only a coarse activity gauge
  always_ff @(posedge mclk) begin
    if (srst) begin
      count_reg <= 16'h0000;
    end else if (anyHit) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_comb begin
    modeWord = 32'h0000_0000;
    modeWord[`F_SHARE +: 3] = sharedSel;
    modeWord[`F_CONV +: 2]  = convMode_reg;
    modeWord[`F_TGT +: 2]   = convTarget_reg;
    modeWord[`F_DAC +: 2]   = modes.dacMode;
    modeWord[`F_RAM +: 2]   = modes.ramMode;
    modeWord[`F_MASK]       = mask_reg;
    modeWord[`F_BOOT +: 2]  = boot_reg;
  end

endmodule
`default_nettype wire

/* File: inc/mcore_defs.svh */
// offsets, field positions, reset values and opcode patterns
// assumes: included by bare name, definitions only
`ifndef MCORE_DEFS_SVH
`define MCORE_DEFS_SVH
// opcode masks and values
`define CRB_MASK 16'hffe8
`define CRB_VAL 16'h35a0
`define CRT_MASK 16'hfff8
`define CRT_VAL 16'h3528
`define DCC_MASK 16'hfffc
`define DCC_VAL 16'h358c
`define DM_MASK 16'hfffc
`define DM_VAL 16'h3584
`define DRM_MASK 16'hfffc
`define DRM_VAL 16'h3580
`define EOA_MASK 16'hfff8
`define EOA_VAL 16'h3570
// operand positions
`define CRB_LVL_BIT 4
`define EOA_MASK_BIT 2
// shortcut codes of the two converter low sides
`define LS7_CODE 4'hd
`define LS8_CODE 4'he
// reset values
`define SHARE_RST 3'h0
`define CONV_RST 2'h0
`define DAC_RST 2'h1
`define RAM_RST 2'h0
`define EOA_MASK_RST 1'h0
`define EOA_BOOT_RST 2'h2
`define CTRL_RST 8'h00
`define TGT_RST 2'h0
// bus map, byte addresses
`define MODE_ADDR 8'h00
`define CTRL_ADDR 8'h04
`define COUNT_ADDR 8'h08
// fields of the mode word
`define F_SHARE 0
`define F_CONV 4
`define F_TGT 6
`define F_DAC 8
`define F_RAM 10
`define F_MASK 12
`define F_BOOT 13
`endif

/* File: inc/mcore_pkg.sv */
// types shared by the mode decoder and its helpers
// assumes: compiled before every other file
`default_nettype none
package mcore_pkg;
  typedef enum logic [1:0] {
    RAM_WORD = 2'h0, RAM_LOW = 2'h1, RAM_HIGH = 2'h2, RAM_SWAP = 2'h3
  } ram_mode_t;
  typedef enum logic [1:0] {
    DAC_NULL = 2'h0, DAC_VALUE = 2'h1, DAC_OFFSET = 2'h2, DAC_FULL = 2'h3
  } dac_mode_t;
  typedef enum logic [1:0] {
    CONV_SYNC = 2'h0, CONV_AUTO = 2'h1, CONV_VDS = 2'h2, CONV_RSVD = 2'h3
  } conv_mode_t;
  typedef enum logic [1:0] {
    BOOT_KEEP = 2'h0, BOOT_ON = 2'h1, BOOT_NEUTRAL = 2'h2, BOOT_OFF = 2'h3
  } boot_code_t;
endpackage
`default_nettype wire

/* File: inc/mode_if.sv */
// carries the read-path mode latches to the helper modules
// assumes: driven by the decoder on one clock
`timescale 1ns/1ns
`default_nettype none
interface mode_if;
  mcore_pkg::ram_mode_t ramMode;
  mcore_pkg::dac_mode_t dacMode;
  modport ctrl (output ramMode, output dacMode);
  modport user (input ramMode, input dacMode);
endinterface
`default_nettype wire

/* File: core/ram_read_shaper.sv */
// shapes a data-ram word on its way to a destination register
// assumes: load strobe and word arrive on mclk
`timescale 1ns/1ns
`default_nettype none
module ram_read_shaper (
  input  wire logic        mclk,
  input  wire logic        srst,
  mode_if.user             modes,
  input  wire logic        loadReq,
  input  wire logic [15:0] ramWord,
  output logic      [15:0] loadData,
  output logic             loadValid
);
  always_ff @(posedge mclk) begin
    if (srst) begin
      loadValid <= 1'b0;
    end else begin
      loadValid <= loadReq;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      loadData <= 16'h0000;
    end else if (loadReq) begin
      case (modes.ramMode)
        mcore_pkg::RAM_LOW:  loadData <= {8'h00, ramWord[7:0]};
        mcore_pkg::RAM_HIGH: loadData <= {8'h00, ramWord[15:8]};
        mcore_pkg::RAM_SWAP: loadData <= {ramWord[7:0], ramWord[15:8]};
        default:             loadData <= ramWord;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: core/dac_read_router.sv */
// picks the dac slice seen by a data-memory read
// assumes: selected threshold dac (5 or 6) is chosen upstream
`timescale 1ns/1ns
`default_nettype none
module dac_read_router (
  input  wire logic        mclk,
  input  wire logic        srst,
  mode_if.user             modes,
  input  wire logic        isCombined,
  input  wire logic [7:0]  dacValue,
  input  wire logic [5:0]  dacOffset,
  input  wire logic [7:0]  thrHigh,
  input  wire logic [3:0]  thrNeg,
  input  wire logic [7:0]  boostValue,
  output logic      [15:0] readData
);
  logic [15:0] plainNext;
  logic [15:0] combNext;

  always_comb begin
    case (modes.dacMode)
      mcore_pkg::DAC_VALUE: begin
        plainNext = {8'h00, dacValue};
        combNext  = {8'h00, thrHigh};
      end
      mcore_pkg::DAC_OFFSET: begin
        plainNext = {2'h0, dacOffset, 8'h00};
        combNext  = {4'h0, thrNeg, 8'h00};
      end
      mcore_pkg::DAC_FULL: begin
        plainNext = {2'h0, dacOffset, dacValue};
        combNext  = {4'h0, thrNeg, thrHigh};
      end
      default: begin
        plainNext = 16'h0000;
        combNext  = {8'h00, boostValue};
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      readData <= 16'h0000;
    end else begin
      readData <= isCombined ? combNext : plainNext;
    end
  end
endmodule
`default_nettype wire

/* File: dv/instr_stream_model.sv */
// program stream model: hands one instruction word a cycle to the decoder
// assumes: the bench raises sendReq just after a rising mclk edge
`timescale 1ns/1ns
`default_nettype none
module instr_stream_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        sendReq,
  input  wire logic [15:0] sendWord,
  input  wire logic [3:0]  sendShortcut,
  output logic             instrValid,
  output logic      [15:0] instrWord,
  output logic      [3:0]  shortcut2Sel
);
  // ****
  // fetch
  // ****
  // idle cycles show the previous cycle's word inverted, so a decoder that ignores valid is caught
  always_ff @(posedge mclk) begin
    if (srst) begin
      instrValid <= 1'b0;
      instrWord  <= 16'hffff;
    end else begin
      instrValid <= sendReq;
      instrWord  <= sendReq ? sendWord : ~instrWord;
    end
  end
  // shortcut 2 is defined ahead of any converter instruction
  always_ff @(posedge mclk) begin
    shortcut2Sel <= srst ? 4'h0 : sendShortcut;
  end
endmodule
`default_nettype wire

/* File: dv/mode_set_checker.sv */
// assertions on the mode latches and the load path of the decoder
// assumes: bound to the decoder top, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module mode_set_checker #(
  parameter int HS_COUNT = 7
) (
  input wire logic                mclk,
  input wire logic                srst,
  input wire logic                instrValid,
  input wire logic [15:0]         instrWord,
  input wire logic [7:0]          ctrlHigh,
  input wire logic [2:0]          sharedSel,
  input wire logic [3:0]          shortcut2Sel,
  input wire logic [1:0]          converterMode,
  input wire logic                convOnLs7,
  input wire logic                convOnLs8,
  input wire logic [1:0]          dacSliceMode,
  input wire logic [1:0]          ramReadMode,
  input wire logic                ramLoadReq,
  input wire logic [15:0]         ramWord,
  input wire logic [15:0]         ramLoadData,
  input wire logic [HS_COUNT-1:0] hsAllowed,
  input wire logic [HS_COUNT-1:0] srcThreshSeen,
  input wire logic [HS_COUNT-1:0] srcThreshRaw,
  input wire logic [HS_COUNT-1:0] bootEnable,
  input wire logic [HS_COUNT-1:0] bootForceOff,
  input wire logic                modeHit,
  input wire logic                eoaMask
);
  // ****
  // opcode matches
  // ****
  logic isCrb, isCrt, isDcc, isDm, isDrm, isEoa;
  assign isCrb = instrValid && (instrWord & 16'hffe8) == 16'h35a0;
  assign isCrt = instrValid && (instrWord & 16'hfff8) == 16'h3528;
  assign isDcc = instrValid && (instrWord & 16'hfffc) == 16'h358c;
  assign isDm  = instrValid && (instrWord & 16'hfffc) == 16'h3584;
  assign isDrm = instrValid && (instrWord & 16'hfffc) == 16'h3580;
  assign isEoa = instrValid && (instrWord & 16'hfff8) == 16'h3570;
  logic anyHit;
  assign anyHit = isCrb || isCrt || isDcc || isDm || isDrm || isEoa;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ****
  // checks
  // ****
  crb_bit_a: assert property (isCrb |=>
    ctrlHigh[$past(instrWord[2:0])] == $past(instrWord[4]))
    else $error("control bit not written");
  shared_sel_a: assert property (isCrt |=> sharedSel == $past(instrWord[2:0]))
    else $error("shared select wrong");
  conv_mode_a: assert property (isDcc && instrWord[1:0] != 2'h3 |=>
    converterMode == $past(instrWord[1:0]))
    else $error("converter mode wrong");
  conv_rsvd_a: assert property (isDcc && instrWord[1:0] == 2'h3 |=>
    $stable(converterMode))
    else $error("reserved converter code acted");
  conv_target_a: assert property (isDcc && instrWord[1:0] != 2'h3 &&
    shortcut2Sel == 4'hd |=> convOnLs7 && !convOnLs8)
    else $error("converter target wrong");
  conv_ls8_a: assert property (isDcc && instrWord[1:0] != 2'h3 &&
    shortcut2Sel == 4'he |=> convOnLs8 && !convOnLs7)
    else $error("converter target wrong");
  thresh_pass_a: assert property (!eoaMask |=>
    srcThreshSeen == $past(srcThreshRaw))
    else $error("unmasked monitor changed");
  boot_on_a: assert property (isEoa && instrWord[1:0] == 2'h1 |=> ##1
    bootEnable == $past(hsAllowed) && bootForceOff == '0)
    else $error("bootstrap enable wrong");
  boot_off_a: assert property (isEoa && instrWord[1:0] == 2'h3 |=> ##1
    bootForceOff == $past(hsAllowed) && bootEnable == '0)
    else $error("bootstrap force off wrong");
  mode_hit_a: assert property (modeHit == $past(anyHit))
    else $error("mode hit pulse wrong");
  dac_mode_a: assert property (isDm |=> dacSliceMode == $past(instrWord[1:0]))
    else $error("dac mode wrong");
  ram_mode_a: assert property (isDrm |=> ramReadMode == $past(instrWord[1:0]))
    else $error("ram mode wrong");
  eoa_mask_a: assert property (isEoa |=> eoaMask == $past(instrWord[2]))
    else $error("mask latch wrong");
  mask_zero_a: assert property (eoaMask |=>
    (srcThreshSeen & $past(hsAllowed)) == '0)
    else $error("masked monitor not zero");
  swap_load_a: assert property (ramLoadReq && ramReadMode == 2'h3 |=>
    ramLoadData == {$past(ramWord[7:0]), $past(ramWord[15:8])})
    else $error("swap load wrong");
  cover property (isDcc && shortcut2Sel == 4'he);
  cover property (ramLoadReq && ramReadMode == 2'h3);
  cover property (isEoa && instrWord[2]);
endmodule
`default_nettype wire

/* File: dv/tb_microcore_mode_set_decoder.sv */
// self-checking bench of the mode-set decoder
// assumes: the design, partner model and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_microcore_mode_set_decoder;
  localparam int HS_COUNT = 7;
  logic mclk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instrValid, modeHit;
  logic convOnLs7, convOnLs8, dacIsCombined, ramLoadReq, ramLoadValid, eoaMask, sendReq, dacChk;
  logic [7:0]  wb_adr_i, ctrlHigh, dacValue, thrHigh, boostValue, ctrl;
  logic [3:0]  wb_sel_i, shortcut2Sel, thrNeg, sendShortcut;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [15:0] instrWord, dacReadData, ramWord, ramLoadData, sendWord;
  logic [5:0]  dacOffset;
  logic [2:0]  sharedSel, share;
  logic [1:0]  converterMode, dacSliceMode, ramReadMode, conv, tgt, dacM, ramM, boot;
  logic        msk;
  logic [HS_COUNT-1:0] hsAllowed, srcThreshRaw, srcThreshSeen, bootEnable, bootForceOff;
  logic [31:0] busQ[$];
  logic [15:0] ldQ[$], dacQ[$];
  int errors, cmpCount, cycles, seed;
  microcore_mode_set_decoder #(.HS_COUNT(HS_COUNT)) u_dut (.*);
  instr_stream_model u_src (.*);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ****
  // expectations
  // ****
  function automatic logic [31:0] modeWord();
    return {17'h0, boot, msk, ramM, dacM, tgt, conv, 1'h0, share};
  endfunction
  function automatic logic [15:0] shape(input logic [1:0] m, input logic [15:0] w);
    case (m)
      2'h0: return w;
      2'h1: return {8'h00, w[7:0]};
      2'h2: return {8'h00, w[15:8]};
      default: return {w[7:0], w[15:8]};
    endcase
  endfunction
  function automatic logic [15:0] dacExp();
    case ({dacIsCombined, dacM})
      3'h0: return 16'h0000;
      3'h1: return {8'h00, dacValue};
      3'h2: return {2'h0, dacOffset, 8'h00};
      3'h3: return {2'h0, dacOffset, dacValue};
      3'h4: return {8'h00, boostValue};
      3'h5: return {8'h00, thrHigh};
      3'h6: return {4'h0, thrNeg, 8'h00};
      default: return {4'h0, thrNeg, thrHigh};
    endcase
  endfunction
  task automatic tally(input logic ok, input string what);
    cmpCount++;
    if (!ok) begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_bus();
    tally(busQ.size() > 0 && wb_dat_o === busQ.pop_front(), "bus read data");
  endtask
  task automatic cmp_load();
    tally(ldQ.size() > 0 && ramLoadData === ldQ.pop_front(), "load data");
  endtask
  task automatic cmp_dac();
    tally(dacQ.size() > 0 && dacReadData === dacQ.pop_front(), "dac read data");
  endtask
  task automatic report_and_stop();
    if (errors == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // drivers
  // ****
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hf};
    if (!we) busQ.push_back(e);
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  // no lowering here, so consecutive calls issue back-to-back instructions
  task automatic exec(input logic [15:0] w);
    @(posedge mclk);
    sendReq <= 1'b1;
    sendWord <= w;
    if ((w & 16'hffe8) == 16'h35a0) ctrl[w[2:0]] = w[4];
    if ((w & 16'hfff8) == 16'h3528) share = w[2:0];
    if ((w & 16'hfffc) == 16'h358c && w[1:0] != 2'h3) begin
      conv = w[1:0];
      if (sendShortcut == 4'hd) tgt = 2'h1;
      if (sendShortcut == 4'he) tgt = 2'h2;
    end
    if ((w & 16'hfffc) == 16'h3584) dacM = w[1:0];
    if ((w & 16'hfffc) == 16'h3580) ramM = w[1:0];
    if ((w & 16'hfff8) == 16'h3570) begin
      msk = w[2];
      if (w[1:0] != 2'h0) boot = w[1:0];
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk) {sendReq, ramLoadReq, dacChk} <= 3'h0;
  endtask
  task automatic load(input logic [15:0] w);
    @(posedge mclk);
    ramLoadReq <= 1'b1;
    ramWord <= w;
    ldQ.push_back(shape(ramM, w));
  endtask
  task automatic dacTry(input int c);
    @(posedge mclk);
    {dacIsCombined, dacValue, dacOffset} <= {1'(c), 14'($random(seed))};
    {thrHigh, thrNeg, boostValue} <= 20'($random(seed));
    @(posedge mclk) dacChk <= 1'b1;
    dacQ.push_back(dacExp());
    idle(1);
  endtask
  // ****
  // monitor and scenarios
  // ****
  always @(posedge mclk) begin
    cycles++;
    if (!srst && wb_ack_o === 1'b1 && !wb_we_i) cmp_bus();
    if (!srst && ramLoadValid === 1'b1) cmp_load();
    if (dacChk) cmp_dac();
    if (cycles > 6000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    seed = 32'h0000_7452;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {sendReq, sendWord, sendShortcut, ramLoadReq, ramWord, dacChk, dacIsCombined} = '0;
    {dacValue, dacOffset, thrHigh, thrNeg, boostValue, hsAllowed, srcThreshRaw} = '0;
    {share, conv, tgt, dacM, ramM, boot, msk, ctrl} = {9'h001, 2'h0, 2'h2, 9'h0};
    srst = 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0, modeWord());
    bus(1'b1, 8'h00, 32'hffff_ffff, 32'h0);
    bus(1'b0, 8'h0c, 32'h0, 32'h0);
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 8; i++) exec({11'h1ad, 1'(i ^ j), 1'b0, 3'(i)});
    idle(2);
    bus(1'b0, 8'h04, 32'h0, {24'h0, ctrl});
    r = $random(seed);
    bus(1'b1, 8'h04, r, 32'h0);
    ctrl = r[7:0];
    bus(1'b0, 8'h04, 32'h0, {24'h0, ctrl});
    for (int i = 0; i < 8; i++) begin
      exec({13'h06a5, 3'(i)});
      idle(2);
      bus(1'b0, 8'h00, 32'h0, modeWord());
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk) sendShortcut <= (k == 0) ? 4'hd : (k == 1) ? 4'he : 4'h3;
      for (int c = 0; c < 4; c++) begin
        exec({14'h0d63, 2'(c)});
        idle(2);
        bus(1'b0, 8'h00, 32'h0, modeWord());
      end
    end
    for (int m = 0; m < 4; m++) begin
      exec({14'h0d61, 2'(m)});
      idle(2);
      dacTry(0);
      dacTry(1);
    end
    for (int m = 0; m < 4; m++) begin
      exec({14'h0d60, 2'(m)});
      idle(2);
      load(16'($random(seed)));
      load(16'($random(seed)));
      idle(2);
    end
    for (int i = 0; i < 8; i++) begin
      hsAllowed <= HS_COUNT'($random(seed));
      srcThreshRaw <= HS_COUNT'($random(seed));
      exec({13'h06ae, 3'(i)});
      idle(3);
      bus(1'b0, 8'h00, 32'h0, modeWord());
    end
    // second reset in mid-run: every latch must fall back to its default
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    {share, conv, tgt, dacM, ramM, boot, msk, ctrl} = {9'h001, 2'h0, 2'h2, 9'h0};
    bus(1'b0, 8'h00, 32'h0, modeWord());
    bus(1'b0, 8'h04, 32'h0, 32'h0);
    bus(1'b0, 8'h08, 32'h0, 32'h0);
    idle(2);
    report_and_stop();
  end
endmodule
bind microcore_mode_set_decoder mode_set_checker #(.HS_COUNT(HS_COUNT)) u_chk (.*);
`default_nettype wire
